// ### design/pmam_defines.svh
//  Notes on behaviour
// - Bus-voltage conversion time is selectable on its own, 50 us to 4120 us.
// - A current result takes a temperature step then a shunt step, 100 us to 8240 us.
// - Averaging of 1 to 1024 rounds applies equally to every enabled channel.
// - Conversion timing and the elapsed-time tick share one timebase.
// - One open-drain alarm pin reports enabled faults or conversion completion.
// - Each result is compared with its limit and raises its flag and the alarm.
// - Six signed 16-bit limits with their own reset values.
// - The diagnostic status register holds one flag per monitored limit.
// - With hold enabled the alarm stays active until the status register is read.
// - With done alarm enabled a finished conversion asserts the alarm.
// - The conversion done flag is always set when a conversion finishes.
// - Averaged compare mode checks limits against averaged results only.
// - The alarm is active low after reset, active high when polarity bit is set.
// - Arithmetic overflow sets a status-only flag that never reaches the alarm.
// - Trim memory health flag reads one while the trim memory is healthy.
// - Energy accumulator overflow sets a status-only flag.
// - Charge accumulator overflow sets a status-only flag.
// - Shutdown stops conversions; registers stay readable and writable.
// - Shutdown lasts until a triggered or continuous mode is written.
// - A triggered conversion finishes and then the sequencer returns to shutdown.
// - Reset restores every register to its default.
// - Setting the software reset bit performs the same full register reset.
// - Done flag clears on a non-shutdown converter config write or a status read.
// - Any mode write aborts the running conversion and restarts per the new mode.
`ifndef PMAM_DEFINES_SVH
`define PMAM_DEFINES_SVH

// ******************************************
// Timebase
// ******************************************
`define PMAM_CLK_MHZ        250

// ******************************************
// Register offsets
// ******************************************
`define PMAM_ADDR_CONFIG    8'h00
`define PMAM_ADDR_ADC_CFG   8'h01
`define PMAM_ADDR_DIAG      8'h0b
`define PMAM_ADDR_CUR_LO    8'h0c
`define PMAM_ADDR_CUR_HI    8'h0d
`define PMAM_ADDR_BUS_HI    8'h0e
`define PMAM_ADDR_BUS_LO    8'h0f
`define PMAM_ADDR_HEAT      8'h10
`define PMAM_ADDR_PWR       8'h11

// ******************************************
// Field positions
// ******************************************
`define PMAM_CFG_RST_BIT    15
`define PMAM_MODE_CONT_BIT  14
`define PMAM_MODE_BUS_BIT   13
`define PMAM_MODE_CUR_BIT   12
`define PMAM_BUS_CT_LO      9
`define PMAM_SHUNT_CT_LO    6
`define PMAM_TEMP_CT_LO     3
`define PMAM_AVG_LO         0
`define PMAM_D_HOLD_BIT     15
`define PMAM_D_DONEEN_BIT   14
`define PMAM_D_AVGCMP_BIT   13
`define PMAM_D_POL_BIT      12
`define PMAM_D_ENERGY_BIT   10
`define PMAM_D_CHARGE_BIT   9
`define PMAM_D_MATH_BIT     8
`define PMAM_D_HEAT_BIT     7
`define PMAM_D_CURHI_BIT    6
`define PMAM_D_CURLO_BIT    5
`define PMAM_D_BUSHI_BIT    4
`define PMAM_D_BUSLO_BIT    3
`define PMAM_D_PWR_BIT      2
`define PMAM_D_DONE_BIT     1
`define PMAM_D_TRIM_BIT     0

// ******************************************
// Conversion times in microseconds and averaging counts
// ******************************************
`define PMAM_CT_US_0        13'd50
`define PMAM_CT_US_1        13'd84
`define PMAM_CT_US_2        13'd150
`define PMAM_CT_US_3        13'd280
`define PMAM_CT_US_4        13'd540
`define PMAM_CT_US_5        13'd1052
`define PMAM_CT_US_6        13'd2074
`define PMAM_CT_US_7        13'd4120
`define PMAM_AVG_0          11'd1
`define PMAM_AVG_1          11'd4
`define PMAM_AVG_2          11'd16
`define PMAM_AVG_3          11'd64
`define PMAM_AVG_4          11'd128
`define PMAM_AVG_5          11'd256
`define PMAM_AVG_6          11'd512
`define PMAM_AVG_7          11'd1024

// ******************************************
// Reset values
// ******************************************
`define PMAM_ADC_CFG_RST    16'h7b68
`define PMAM_DIAG_CTL_RST   4'h0
`define PMAM_CUR_LO_RST     16'h8000
`define PMAM_CUR_HI_RST     16'h7fff
`define PMAM_BUS_HI_RST     16'h7fff
`define PMAM_BUS_LO_RST     16'h0000
`define PMAM_HEAT_RST       16'hffff
`define PMAM_PWR_RST        16'h7fff

`endif

// ### design/pmam_pkg.sv
// ******************************************
// Shared types
// ******************************************
package pmam_pkg;

    // Sequencer steps of one averaging round.
    typedef enum logic [1:0] {
        PMAM_ST_IDLE,
        PMAM_ST_TEMP,
        PMAM_ST_SHUNT,
        PMAM_ST_BUS
    } pmam_state_t;

    // One set of results from the calculation engine.
    typedef struct packed {
        logic signed [15:0] current;
        logic signed [15:0] bus;
        logic signed [15:0] temp;
        logic signed [15:0] power;
    } pmam_meas_t;

    // Register access from the serial interface.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } pmam_reg_req_t;

    // Sequencer view for the converter front end.
    typedef struct packed {
        logic       busy;
        logic [1:0] step;
        logic       step_end;
        logic       round_end;
        logic       done;
    } pmam_adc_ctl_t;

endpackage : pmam_pkg

// ### design/pmam_alarm_core.sv
`timescale 1ns/1ps
`include "pmam_defines.svh"

module pmam_alarm_core #(
    parameter int US_CYCLES = `PMAM_CLK_MHZ
) (
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire pmam_pkg::pmam_reg_req_t reg_req_in,
    output logic [15:0]                 reg_rdata_out,
    input  wire logic                   sample_valid_in,
    input  wire pmam_pkg::pmam_meas_t    sample_in,
    input  wire logic                   avg_valid_in,
    input  wire pmam_pkg::pmam_meas_t    avg_in,
    input  wire logic                   math_ovf_in,
    input  wire logic                   energy_ovf_in,
    input  wire logic                   charge_ovf_in,
    input  wire logic                   trim_ok_in,
    output pmam_pkg::pmam_adc_ctl_t      adc_ctl_out,
    output logic                        time_tick_out,
    output logic                        alert_out,
    output logic                        alert_oe_out
);
    import pmam_pkg::*;

    // ******************************************
    // Elaboration checks
    // ******************************************
    if (US_CYCLES < 1) begin : g_bad_div
        $error("US_CYCLES must be at least one.");
    end

    // ******************************************
    // Lookups
    // ******************************************
    function automatic logic [12:0] ct_us(input logic [2:0] code);
        logic [12:0] t;
        t = `PMAM_CT_US_0;
        unique case (code)
            3'h0: t = `PMAM_CT_US_0;
            3'h1: t = `PMAM_CT_US_1;
            3'h2: t = `PMAM_CT_US_2;
            3'h3: t = `PMAM_CT_US_3;
            3'h4: t = `PMAM_CT_US_4;
            3'h5: t = `PMAM_CT_US_5;
            3'h6: t = `PMAM_CT_US_6;
            3'h7: t = `PMAM_CT_US_7;
        endcase
        return t;
    endfunction : ct_us

    function automatic logic [10:0] avg_n(input logic [2:0] code);
        logic [10:0] n;
        n = `PMAM_AVG_0;
        unique case (code)
            3'h0: n = `PMAM_AVG_0;
            3'h1: n = `PMAM_AVG_1;
            3'h2: n = `PMAM_AVG_2;
            3'h3: n = `PMAM_AVG_3;
            3'h4: n = `PMAM_AVG_4;
            3'h5: n = `PMAM_AVG_5;
            3'h6: n = `PMAM_AVG_6;
            3'h7: n = `PMAM_AVG_7;
        endcase
        return n;
    endfunction : avg_n

    // ******************************************
    // Register file
    // ******************************************
    logic [15:0] adc_cfg_q, adc_cfg_d;
    logic [3:0]  diag_ctl_q, diag_ctl_d;
    logic [15:0] cur_lo_q, cur_lo_d, cur_hi_q, cur_hi_d;
    logic [15:0] bus_hi_q, bus_hi_d, bus_lo_q, bus_lo_d;
    logic [15:0] heat_q, heat_d, pwr_q, pwr_d;
    logic        swrst_q, swrst_d;
    logic        wr_cfg, rd_diag;
    logic        hold_en, done_en, avg_cmp, pol_high;

    assign wr_cfg   = reg_req_in.wr && (reg_req_in.addr == `PMAM_ADDR_ADC_CFG);
    assign rd_diag  = reg_req_in.rd && (reg_req_in.addr == `PMAM_ADDR_DIAG);
    assign hold_en  = diag_ctl_q[3];
    assign done_en  = diag_ctl_q[2];
    assign avg_cmp  = diag_ctl_q[1];
    assign pol_high = diag_ctl_q[0];

    // Writes land here; the software reset pulse is taken one cycle after its write.
    always_comb begin
        adc_cfg_d  = adc_cfg_q;
        diag_ctl_d = diag_ctl_q;
        cur_lo_d   = cur_lo_q;
        cur_hi_d   = cur_hi_q;
        bus_hi_d   = bus_hi_q;
        bus_lo_d   = bus_lo_q;
        heat_d     = heat_q;
        pwr_d      = pwr_q;
        swrst_d    = 1'b0;
        if (swrst_q) begin
            adc_cfg_d  = `PMAM_ADC_CFG_RST;
            diag_ctl_d = `PMAM_DIAG_CTL_RST;
            cur_lo_d   = `PMAM_CUR_LO_RST;
            cur_hi_d   = `PMAM_CUR_HI_RST;
            bus_hi_d   = `PMAM_BUS_HI_RST;
            bus_lo_d   = `PMAM_BUS_LO_RST;
            heat_d     = `PMAM_HEAT_RST;
            pwr_d      = `PMAM_PWR_RST;
        end else if (reg_req_in.wr) begin
            unique case (reg_req_in.addr)
                `PMAM_ADDR_CONFIG:  swrst_d = reg_req_in.wdata[`PMAM_CFG_RST_BIT];
                `PMAM_ADDR_ADC_CFG: adc_cfg_d = reg_req_in.wdata;
                `PMAM_ADDR_DIAG:    diag_ctl_d = reg_req_in.wdata[15:12];
                `PMAM_ADDR_CUR_LO:  cur_lo_d = reg_req_in.wdata;
                `PMAM_ADDR_CUR_HI:  cur_hi_d = reg_req_in.wdata;
                `PMAM_ADDR_BUS_HI:  bus_hi_d = reg_req_in.wdata;
                `PMAM_ADDR_BUS_LO:  bus_lo_d = reg_req_in.wdata;
                `PMAM_ADDR_HEAT:    heat_d = reg_req_in.wdata;
                `PMAM_ADDR_PWR:     pwr_d = reg_req_in.wdata;
                default:            swrst_d = 1'b0;
            endcase
        end
    end

    // Registers keep working in shutdown, so nothing here looks at the mode.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            adc_cfg_q  <= `PMAM_ADC_CFG_RST;
            diag_ctl_q <= `PMAM_DIAG_CTL_RST;
            cur_lo_q   <= `PMAM_CUR_LO_RST;
            cur_hi_q   <= `PMAM_CUR_HI_RST;
            bus_hi_q   <= `PMAM_BUS_HI_RST;
            bus_lo_q   <= `PMAM_BUS_LO_RST;
            heat_q     <= `PMAM_HEAT_RST;
            pwr_q      <= `PMAM_PWR_RST;
            swrst_q    <= 1'b0;
        end else begin
            adc_cfg_q  <= adc_cfg_d;
            diag_ctl_q <= diag_ctl_d;
            cur_lo_q   <= cur_lo_d;
            cur_hi_q   <= cur_hi_d;
            bus_hi_q   <= bus_hi_d;
            bus_lo_q   <= bus_lo_d;
            heat_q     <= heat_d;
            pwr_q      <= pwr_d;
            swrst_q    <= swrst_d;
        end
    end

    // ******************************************
    // Conversion sequencer
    // ******************************************
    pmam_state_t st_q, st_d;
    logic [15:0] pre_q, pre_d;
    logic [12:0] us_q, us_d;
    logic [10:0] rnd_q, rnd_d;
    logic        start_q, start_d;
    logic        tick, step_end, round_end, done, cur_en, bus_en;
    logic [12:0] step_us;
    pmam_state_t first_st;

    assign cur_en   = adc_cfg_q[`PMAM_MODE_CUR_BIT];
    assign bus_en   = adc_cfg_q[`PMAM_MODE_BUS_BIT];
    assign first_st = cur_en ? PMAM_ST_TEMP : PMAM_ST_BUS;
    assign tick     = (pre_q == 16'(US_CYCLES - 1));

    // Pick the length of the step in progress; each channel has its own code.
    always_comb begin
        step_us = ct_us(adc_cfg_q[`PMAM_BUS_CT_LO +: 3]);
        if (st_q == PMAM_ST_TEMP) begin
            step_us = ct_us(adc_cfg_q[`PMAM_TEMP_CT_LO +: 3]);
        end else if (st_q == PMAM_ST_SHUNT) begin
            step_us = ct_us(adc_cfg_q[`PMAM_SHUNT_CT_LO +: 3]);
        end
    end

    assign step_end  = (st_q != PMAM_ST_IDLE) && tick && (us_q == step_us - 13'd1);
    assign round_end = step_end && ((st_q == PMAM_ST_BUS) || (st_q == PMAM_ST_SHUNT && !bus_en));
    assign done      = round_end && (rnd_q + 11'd1 == avg_n(adc_cfg_q[`PMAM_AVG_LO +: 3]));

    // A mode write wins over the running step: it aborts and restarts.
    always_comb begin
        st_d    = st_q;
        us_d    = us_q;
        rnd_d   = rnd_q;
        start_d = 1'b0;
        pre_d   = tick ? 16'h0000 : pre_q + 16'h0001;
        if (swrst_q || wr_cfg) begin
            st_d    = PMAM_ST_IDLE;
            rnd_d   = 11'h000;
            start_d = 1'b1;
        end else if (start_q) begin
            us_d  = 13'h0000;
            pre_d = 16'h0000;
            if (cur_en || bus_en) begin
                st_d = first_st;
            end
        end else if (step_end) begin
            us_d = 13'h0000;
            unique case (st_q)
                PMAM_ST_TEMP:  st_d = PMAM_ST_SHUNT;
                PMAM_ST_SHUNT: st_d = bus_en ? PMAM_ST_BUS : first_st;
                PMAM_ST_BUS:   st_d = first_st;
                PMAM_ST_IDLE:  st_d = PMAM_ST_IDLE;
            endcase
            if (round_end) begin
                rnd_d = rnd_q + 11'd1;
            end
            if (done) begin
                rnd_d = 11'h000;
                if (!adc_cfg_q[`PMAM_MODE_CONT_BIT]) begin
                    st_d = PMAM_ST_IDLE;
                end
            end
        end else if (tick && st_q != PMAM_ST_IDLE) begin
            us_d = us_q + 13'd1;
        end
    end

    // The start flag comes out of reset set, so the default mode runs at once.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q    <= PMAM_ST_IDLE;
            pre_q   <= 16'h0000;
            us_q    <= 13'h0000;
            rnd_q   <= 11'h000;
            start_q <= 1'b1;
        end else begin
            st_q    <= st_d;
            pre_q   <= pre_d;
            us_q    <= us_d;
            rnd_q   <= rnd_d;
            start_q <= start_d;
        end
    end

    // ******************************************
    // Limit compare and status flags
    // ******************************************
    logic [5:0] cond_q, cond_d, held_q, held_d, view;
    logic [2:0] ovf_q, ovf_d;
    logic       done_q, done_d;
    logic       cmp_now;
    pmam_meas_t m;

    assign cmp_now = avg_cmp ? avg_valid_in : sample_valid_in;
    assign m       = avg_cmp ? avg_in : sample_in;
    assign view    = hold_en ? held_q : cond_q;

    // Conditions track the latest result; held copies set-win over the read clear.
    always_comb begin
        cond_d = cond_q;
        if (cmp_now) begin
            cond_d[5] = m.temp > $signed(heat_q);
            cond_d[4] = m.current > $signed(cur_hi_q);
            cond_d[3] = m.current < $signed(cur_lo_q);
            cond_d[2] = m.bus > $signed(bus_hi_q);
            cond_d[1] = m.bus < $signed(bus_lo_q);
            cond_d[0] = m.power > $signed(pwr_q);
        end
        held_d = (rd_diag ? 6'h00 : held_q) | cond_d;
        ovf_d  = (rd_diag ? 3'h0 : ovf_q) | {energy_ovf_in, charge_ovf_in, math_ovf_in};
        done_d = done || (done_q && !rd_diag && !(wr_cfg
                 && (reg_req_in.wdata[`PMAM_MODE_CUR_BIT] || reg_req_in.wdata[`PMAM_MODE_BUS_BIT])));
        if (swrst_q) begin
            cond_d = 6'h00;
            held_d = 6'h00;
            ovf_d  = 3'h0;
            done_d = 1'b0;
        end
    end

    // The done flag is set on every completion, independent of the alarm enable.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cond_q <= 6'h00;
            held_q <= 6'h00;
            ovf_q  <= 3'h0;
            done_q <= 1'b0;
        end else begin
            cond_q <= cond_d;
            held_q <= held_d;
            ovf_q  <= ovf_d;
            done_q <= done_d;
        end
    end

    // ******************************************
    // Alarm pin
    // ******************************************
    logic act_q, act_d, hold_act_q, hold_act_d, oe_d;

    // Overflow and trim flags are left out on purpose: they are status only.
    always_comb begin
        act_d      = (|view) || (done_en && done_q);
        hold_act_d = hold_en && !rd_diag && (hold_act_q || act_d);
        if (swrst_q) begin
            hold_act_d = 1'b0;
        end
        oe_d = (act_d || hold_act_q) ^ pol_high;
    end

    // Open drain: enable high pulls the pin low; the data line is always zero.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            act_q        <= 1'b0;
            hold_act_q   <= 1'b0;
            alert_oe_out <= 1'b0;
            alert_out    <= 1'b0;
        end else begin
            act_q        <= act_d;
            hold_act_q   <= hold_act_d;
            alert_oe_out <= oe_d;
            alert_out    <= 1'b0;
        end
    end

    // ******************************************
    // Read data and front-end outputs
    // ******************************************
    logic [15:0] rdata_d;

    // Unmapped and write-only locations read as zero.
    always_comb begin
        rdata_d = 16'h0000;
        unique case (reg_req_in.addr)
            `PMAM_ADDR_ADC_CFG: rdata_d = adc_cfg_q;
            `PMAM_ADDR_DIAG:    rdata_d = {diag_ctl_q, 1'b0, ovf_q,
                                           view[5:0], done_q, trim_ok_in};
            `PMAM_ADDR_CUR_LO:  rdata_d = cur_lo_q;
            `PMAM_ADDR_CUR_HI:  rdata_d = cur_hi_q;
            `PMAM_ADDR_BUS_HI:  rdata_d = bus_hi_q;
            `PMAM_ADDR_BUS_LO:  rdata_d = bus_lo_q;
            `PMAM_ADDR_HEAT:    rdata_d = heat_q;
            `PMAM_ADDR_PWR:     rdata_d = pwr_q;
            default:            rdata_d = 16'h0000;
        endcase
    end

    // Front-end strobes are one cycle late so they leave from flip-flops.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
            adc_ctl_out   <= '0;
            time_tick_out <= 1'b0;
        end else begin
            reg_rdata_out         <= reg_req_in.rd ? rdata_d : reg_rdata_out;
            adc_ctl_out.busy      <= st_d != PMAM_ST_IDLE;
            adc_ctl_out.step      <= st_d;
            adc_ctl_out.step_end  <= step_end;
            adc_ctl_out.round_end <= round_end;
            adc_ctl_out.done      <= done;
            time_tick_out         <= tick && (st_q != PMAM_ST_IDLE);
        end
    end

endmodule : pmam_alarm_core

// ### bench/pmam_host_model.sv
`timescale 1ns/1ps
// ******
// Host side of the alarm wire
// ******
module pmam_host_model (
    input  wire logic alert_in,
    input  wire logic alert_oe_in,
    output logic      pin_out
);
    // The pull-up owns the wire whenever the device lets go of it.
    assign pin_out = alert_oe_in ? alert_in : 1'b1;
endmodule : pmam_host_model

// ### bench/pmam_alarm_checker.sv
`timescale 1ns/1ps
// ******
// Port checker
// ******
module pmam_alarm_checker (
    input wire logic                    clk_in,
    input wire logic                    rst_n_in,
    input wire pmam_pkg::pmam_reg_req_t reg_req_in,
    input wire logic [15:0]             reg_rdata_out,
    input wire logic                    trim_ok_in,
    input wire pmam_pkg::pmam_adc_ctl_t adc_ctl_out,
    input wire logic                    alert_out
);
    import pmam_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Decoded strobes; the shutdown, restart, trim, limit and soft-reset checks start from one of them.
    sequence s_wr(a);
        reg_req_in.wr && reg_req_in.addr == a;
    endsequence
    sequence s_rd(a);
        reg_req_in.rd && reg_req_in.addr == a;
    endsequence
    AST_OPEN_DRAIN: assert property (
        alert_out == 1'b0)
        else $error("alarm data not low");
    AST_SHUTDOWN: assert property (
        s_wr(8'h01) ##0 reg_req_in.wdata[13:12] == 2'b00 |-> ##3 (!adc_ctl_out.busy) [*8])
        else $error("sequencer runs in shutdown");
    AST_RESTART: assert property (
        s_wr(8'h01) ##0 reg_req_in.wdata[13:12] != 2'b00 |-> ##3 adc_ctl_out.busy)
        else $error("mode write did not restart");
    AST_SHUNT_AFTER_TEMP: assert property (
        adc_ctl_out.step == PMAM_ST_SHUNT
        |-> $past(adc_ctl_out.step) inside {PMAM_ST_TEMP, PMAM_ST_SHUNT})
        else $error("shunt step without temperature step");
    AST_TRIM: assert property (
        s_rd(8'h0b) |-> ##1 reg_rdata_out[0] == $past(trim_ok_in))
        else $error("trim health bit wrong");
    AST_LIMIT_RW: assert property (
        s_wr(8'h0c) ##1 s_rd(8'h0c) |-> ##1 reg_rdata_out == $past(reg_req_in.wdata, 2))
        else $error("limit read back wrong");
    AST_SOFT_RESET: assert property (
        s_wr(8'h00) ##0 reg_req_in.wdata[15] ##[2:3] s_rd(8'h0c)
        |-> ##1 reg_rdata_out == 16'h8000)
        else $error("soft reset left a limit");
    AST_DONE_FLAG: assert property (
        adc_ctl_out.done ##[2:4] s_rd(8'h0b) |-> ##1 reg_rdata_out[1])
        else $error("done flag missing");
endmodule : pmam_alarm_checker

// ### bench/tb_power_monitor_alert_and_modes.sv
`timescale 1ns/1ps
// ******
// Bench
// ******
module tb_power_monitor_alert_and_modes;
    import pmam_pkg::*;
    logic          clk, rst_n, sv, av, mo, eo, co, trim, pin, alrt, aoe, tck;
    logic [1:0]    rp;
    logic [15:0]   rdata, v;
    logic [31:0]   eq[$];
    pmam_reg_req_t req;
    pmam_meas_t    smp;
    pmam_adc_ctl_t ctl;
    int            n_errors, total_checks, cyc, i;

    pmam_alarm_core #(.US_CYCLES(1)) uut (
        .clk_in(clk), .rst_n_in(rst_n), .reg_req_in(req), .reg_rdata_out(rdata),
        .sample_valid_in(sv), .sample_in(smp), .avg_valid_in(av), .avg_in(smp),
        .math_ovf_in(mo), .energy_ovf_in(eo), .charge_ovf_in(co), .trim_ok_in(trim),
        .adc_ctl_out(ctl), .time_tick_out(tck), .alert_out(alrt), .alert_oe_out(aoe));
    pmam_host_model host (.alert_in(alrt), .alert_oe_in(aoe), .pin_out(pin));

    initial clk = 1'b0;
    // Free-running 250 MHz clock.
    always #2 clk = ~clk;

    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    // Optional write, then optional read whose masked value is noted for the monitor.
    task automatic op(input logic [7:0] a, input logic w, r, input logic [15:0] d, e, m);
        if (w) begin
            req = '{1'b1, 1'b0, a, d};
            idle(1);
        end
        if (r) begin
            req = '{1'b0, 1'b1, a, 16'h0000};
            eq.push_back({e, m});
            idle(1);
        end
        req = '0;
        idle(1);
    endtask : op
    task automatic pin_is(input logic x);
        idle(3);
        chk(pin === x, "alarm pin");
    endtask : pin_is
    task automatic feed(input logic a, input logic [15:0] c);
        smp.current = c;
        if (a) av = 1'b1;
        else sv = 1'b1;
        idle(1);
        {sv, av} = 2'b00;
        idle(1);
    endtask : feed
    task automatic wait_done();
        for (int k = 0; k < 400 && ctl.done !== 1'b1; k++) idle(1);
        chk(ctl.done === 1'b1, "no done pulse");
        idle(3);
    endtask : wait_done
    task automatic defaults();
        logic [15:0] t[6];
        t = '{16'h8000, 16'h7fff, 16'h7fff, 16'h0000, 16'hffff, 16'h7fff};
        for (int k = 0; k < 6; k++) op(8'(8'h0c + k), 0, 1, 0, t[k], 16'hffff);
        op(8'h01, 0, 1, 0, 16'h7b68, 16'hffff);
    endtask : defaults

    // Read data is judged half a cycle after the second clock edge that follows its strobe, when it has surely settled.
    always @(posedge clk) rp <= {rp[0], req.rd};
    always @(negedge clk) if (rp[1]) begin
        chk((rdata & eq[0][15:0]) === eq[0][31:16], "register read");
        void'(eq.pop_front());
    end
    // Cuts a hang short far beyond the few hundred cycles the run needs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            $display("wrong value at %0t: timeout", $time);
            finish_test();
        end
    end

    // Main sequence; temperature sits at the most negative code so it never trips.
    initial begin
        void'($urandom(32'hb7cb91fa));
        {sv, av, mo, eo, co} = '0;
        trim = 1'($urandom);
        req = '0;
        smp = '{16'h0000, 16'h0000, 16'h8000, 16'h0000};
        rst_n = 1'b0;
        idle(4);
        rst_n = 1'b1;
        defaults();
        pin_is(1'b1);
        op(8'h01, 1, 0, 16'h0000, 0, 0);
        idle(12);
        chk(ctl.busy === 1'b0, "busy in shutdown");
        chk(tck === 1'b0, "tick in shutdown");
        for (i = 0; i < 6; i++) begin
            v = 16'($urandom);
            op(8'(8'h0c + i), 1, 1, v, v, 16'hffff);
        end
        op(8'h0b, 0, 1, 0, {15'h0000, trim}, 16'h0001);
        op(8'h00, 1, 0, 16'h8000, 0, 0);
        defaults();
        op(8'h01, 1, 0, 16'h0000, 0, 0);
        idle(12);
        op(8'h01, 1, 0, 16'h1000, 0, 0);
        idle(2);
        chk(ctl.busy === 1'b1, "trigger ignored");
        chk(tck === 1'b1, "no time tick");
        wait_done();
        op(8'h0b, 0, 1, 0, 16'h0002, 16'h0002);
        op(8'h0b, 0, 1, 0, 16'h0000, 16'h0002);
        idle(8);
        chk(ctl.busy === 1'b0, "no return to shutdown");
        op(8'h0d, 1, 0, 16'h0064, 0, 0);
        feed(0, 16'd200);
        pin_is(1'b0);
        op(8'h0b, 0, 1, 0, 16'h0040, 16'h0040);
        feed(0, 16'd0);
        pin_is(1'b1);
        op(8'h0b, 1, 0, 16'h1000, 0, 0);
        pin_is(1'b0);
        op(8'h0b, 1, 0, 16'h8000, 0, 0);
        feed(0, 16'd200);
        feed(0, 16'd0);
        pin_is(1'b0);
        op(8'h0b, 0, 1, 0, 16'h0040, 16'h0040);
        pin_is(1'b1);
        op(8'h0b, 1, 0, 16'h2000, 0, 0);
        feed(0, 16'd200);
        pin_is(1'b1);
        feed(1, 16'd200);
        pin_is(1'b0);
        feed(1, 16'd0);
        {mo, eo, co} = 3'b111;
        idle(1);
        {mo, eo, co} = 3'b000;
        pin_is(1'b1);
        op(8'h0b, 0, 1, 0, 16'h0700, 16'h0700);
        op(8'h0b, 1, 0, 16'h4000, 0, 0);
        op(8'h01, 1, 0, 16'h1000, 0, 0);
        wait_done();
        pin_is(1'b0);
        op(8'h0b, 0, 1, 0, 16'h0002, 16'h0002);
        pin_is(1'b1);
        finish_test();
    end
endmodule : tb_power_monitor_alert_and_modes

bind pmam_alarm_core pmam_alarm_checker chk_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .trim_ok_in(trim_ok_in),
    .adc_ctl_out(adc_ctl_out), .alert_out(alert_out));
